// File: bench/plb_block_tb.sv
// self-checking bench for one logic block: apb setup, pin walks, feedback
// assumes the board model beside it and a 40 MHz clock
`timescale 1ns/10ps
`default_nettype none
module plb_block_tb;
    import plb_pkg::*;
    logic clk = 0, rst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic [NUM_DED-1:0] ded_in = '0;
    logic [NUM_CKP-1:0] ckp_in = '0;
    logic [NUM_PIN-1:0] io_in, io_out, io_oe_n, drv_val = '0, drv_en = '0;
    logic [EXT_FB-1:0] other_fb = '0;
    logic [FB_PER_BLK-1:0] fb_out;
    logic [AW-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic pready, pslverr;
    logic [32:0] expq [$];
    logic [32:0] exp_w;
    int bad_count = 0, comparisons = 0, seed = 80093;
    plb_block DUT (.clk(clk), .rst(rst), .ce(ce), .ded_in(ded_in), .ckp_in(ckp_in), .io_in(io_in),
        .io_out(io_out), .io_oe_n(io_oe_n), .other_fb(other_fb), .fb_out(fb_out), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    plb_board board (.drv_val(drv_val), .drv_en(drv_en), .io_out(io_out), .io_oe_n(io_oe_n), .io_in(io_in));
    // 25 ns clock
    always #12.5 clk = ~clk;
    task automatic conclude();
        if (bad_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (e !== g) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one apb transfer; the expected answer goes to the queue
    task automatic xfer(input logic wr, input logic [AW-1:0] a, input logic [31:0] d, input logic err);
        expq.push_back({err, d});
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // drive pins, let the block evaluate, then look at pin 0 and the feedback of macrocell 0
    task automatic step(input logic [3:0] d, input logic ck, input logic e);
        @(posedge clk);
        ded_in <= d;
        ckp_in[0] <= ck;
        repeat (3) @(posedge clk);
        #1;
        chk("io_out0", e, io_out[0]);
        chk("fb_out0", e, fb_out[0]);
    endtask
    // configure macrocell 0, then run six steps of {expect, clock, inputs}
    task automatic walk(input logic [6:0] cfg, input logic [5:0] s [6]);
        xfer(1'b1, OFS_MC, {25'h0, cfg}, 1'b0);
        for (int i = 0; i < 6; i++) step(s[i][3:0], s[i][4], s[i][5]);
    endtask
    // monitor: every completed transfer takes the oldest note
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && expq.size() > 0) begin
            exp_w = expq.pop_front();
            comparisons++;
            if (pslverr !== exp_w[32] || (!pwrite && prdata !== exp_w[31:0])) begin
                bad_count++;
                $display("[ERR] apb %h expected %h seen %h", paddr, exp_w, {pslverr, prdata});
            end
        end
    end
    // watchdog
    initial begin
        #(25 * 20000);
        bad_count++;
        conclude();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("oe_n_reset", 32'h3f, {26'h0, io_oe_n});
        xfer(1'b0, OFS_STAT, 32'h0003_f000, 1'b0);
        xfer(1'b0, 12'h3e4, 32'h0, 1'b1);
        xfer(1'b1, OFS_STAT, 32'h1, 1'b1);
        xfer(1'b0, 12'h002, 32'h0, 1'b1);
        for (int i = 0; i < NUM_DED; i++) xfer(1'b1, OFS_SEL + 12'(4 * i), 32'(i), 1'b0);
        xfer(1'b1, OFS_SEL + 12'h064, 32'h97, 1'b0);
        xfer(1'b0, OFS_SEL + 12'h064, 32'h97, 1'b0);
        xfer(1'b0, OFS_SEL + 12'h008, 32'h2, 1'b0);
        xfer(1'b1, OFS_TERM, 32'h1, 1'b0);
        xfer(1'b1, OFS_TERM + 12'h180, 32'h8, 1'b0);
        xfer(1'b1, OFS_TERM + 12'h190, 32'h2, 1'b0);
        xfer(1'b1, OFS_TERM + 12'h198, 32'h4, 1'b0);
        xfer(1'b1, OFS_CLU, 32'h6, 1'b0);
        xfer(1'b1, OFS_OE, 32'h1, 1'b0);
        xfer(1'b1, OFS_MC, 32'h0, 1'b0);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            ded_in <= 4'($random(seed));
            repeat (3) @(posedge clk);
            #1;
            chk("comb_out", {31'h0, ded_in[0]}, {31'h0, io_out[0]});
        end
        walk(7'h01, '{6'h31, 6'h30, 6'h20, 6'h10, 6'h10, 6'h10});
        walk(7'h09, '{6'h01, 6'h31, 6'h21, 6'h11, 6'h00, 6'h10});
        walk(7'h01, '{6'h11, 6'h35, 6'h31, 6'h13, 6'h17, 6'h35});
        walk(7'h02, '{6'h21, 6'h00, 6'h21, 6'h31, 6'h30, 6'h00});
        walk(7'h10, '{6'h01, 6'h20, 6'h20, 6'h20, 6'h20, 6'h20});
        xfer(1'b1, OFS_OE, 32'h2, 1'b0);
        for (int v = 0; v < 2; v++) begin
            step({v[0], 3'h0}, 1'b0, 1'b1);
            chk("oe_term", {31'h0, !v[0]}, {31'h0, io_oe_n[0]});
        end
        xfer(1'b1, OFS_OE, 32'h0, 1'b0);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            drv_en <= 6'h01;
            drv_val <= 6'($random(seed));
            repeat (3) @(posedge clk);
            #1;
            chk("oe_off", 32'h1, {31'h0, io_oe_n[0]});
            chk("pin_fb", {31'h0, drv_val[0]}, {31'h0, fb_out[12]});
        end
        // clock enable low: pin feedback must keep the old level
        @(posedge clk);
        ce <= 1'b0;
        drv_val <= ~drv_val;
        repeat (3) @(posedge clk);
        #1;
        chk("ce_hold", {31'h0, ~drv_val[0]}, {31'h0, fb_out[12]});
        @(posedge clk);
        ce <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk("ce_resume", {31'h0, drv_val[0]}, {31'h0, fb_out[12]});
        repeat (2) @(posedge clk);
        conclude();
    end
endmodule
`default_nettype wire

// File: bench/plb_board.sv
// board model: resolves the six shared pins of one logic block
// assumes pull-ups on every pin, so an undriven pin reads high
`timescale 1ns/10ps
`default_nettype none
module plb_board (
    input wire logic [plb_pkg::NUM_PIN-1:0] drv_val,
    input wire logic [plb_pkg::NUM_PIN-1:0] drv_en,
    input wire logic [plb_pkg::NUM_PIN-1:0] io_out,
    input wire logic [plb_pkg::NUM_PIN-1:0] io_oe_n,
    output logic [plb_pkg::NUM_PIN-1:0] io_in
);
    import plb_pkg::*;
    // block drive first, then board drive, else pull-up
    always_comb begin
        for (int k = 0; k < NUM_PIN; k++) begin
            io_in[k] = !io_oe_n[k] ? io_out[k] : (drv_en[k] ? drv_val[k] : 1'b1);
        end
    end
endmodule
`default_nettype wire

// File: hdl/plb_block.sv
// one logic block with its switch matrix, allocator, macrocells and pin cells
// configuration is loaded over apb; all pins are sampled on clk
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module plb_block (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [plb_pkg::NUM_DED-1:0] ded_in,
    input wire logic [plb_pkg::NUM_CKP-1:0] ckp_in,
    input wire logic [plb_pkg::NUM_PIN-1:0] io_in,
    output logic [plb_pkg::NUM_PIN-1:0] io_out,
    output logic [plb_pkg::NUM_PIN-1:0] io_oe_n,
    input wire logic [plb_pkg::EXT_FB-1:0] other_fb,
    output logic [plb_pkg::FB_PER_BLK-1:0] fb_out,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [plb_pkg::AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    import plb_pkg::*;

    typedef struct packed {
        logic [NUM_SW-1:0][SEL_W-1:0] sel;
        logic [NUM_PT-1:0][NUM_LIT-1:0] mask;
        logic [NUM_CLU-1:0][2:0] steer;
        logic [NUM_MC-1:0][MC_CFG_W-1:0] mccfg;
        logic [NUM_PIN-1:0][1:0] oecfg;
        logic [NUM_MC-1:0] q;
        logic [NUM_CKP-1:0] ckp_q;
        logic [NUM_PIN-1:0] io_out;
        logic [NUM_PIN-1:0] io_oe_n;
        logic [FB_PER_BLK-1:0] fb;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } plb_state_type;

    plb_state_type st_r;
    plb_state_type st_nxt;
    logic [NUM_SRC-1:0] src;
    logic [NUM_SW-1:0] sw;
    logic [NUM_LIT-1:0] lits;
    logic [NUM_PT-1:0] pt;
    logic [NUM_MC-1:0] sum;
    logic [NUM_MC-1:0] qn;
    logic [NUM_CKP-1:0] ck_rise;
    plb_reg_type rg;
    logic [5:0] ridx;

    // picks one matrix source; out-of-range selections read as zero
    function automatic logic pick_src(input logic [NUM_SRC-1:0] s, input logic [SEL_W-1:0] i);
        pick_src = (int'(i) < NUM_SRC) ? s[i] : 1'b0;
    endfunction

    // decodes an apb address into a register group and index
    function automatic plb_reg_type dec_grp(input logic [AW-1:0] a);
        if (a[1:0] != 2'h0) begin
            dec_grp = RG_NONE;
        end else if (a < OFS_SEL + AW'(4 * NUM_SW)) begin
            dec_grp = RG_SEL;
        end else if (a >= OFS_TERM && a < OFS_TERM + AW'(8 * NUM_PT)) begin
            dec_grp = a[2] ? RG_THI : RG_TLO;
        end else if (a >= OFS_CLU && a < OFS_CLU + AW'(4 * NUM_CLU)) begin
            dec_grp = RG_CLU;
        end else if (a >= OFS_MC && a < OFS_MC + AW'(4 * NUM_MC)) begin
            dec_grp = RG_MC;
        end else if (a >= OFS_OE && a < OFS_OE + AW'(4 * NUM_PIN)) begin
            dec_grp = RG_OE;
        end else if (a == OFS_STAT) begin
            dec_grp = RG_STAT;
        end else begin
            dec_grp = RG_NONE;
        end
    endfunction

    function automatic logic [5:0] dec_idx(input logic [AW-1:0] a, input plb_reg_type g);
        logic [AW-1:0] d;
        d = '0;
        case (g)
            RG_SEL: d = (a - OFS_SEL) >> 2;
            RG_TLO, RG_THI: d = (a - OFS_TERM) >> 3;
            RG_CLU: d = (a - OFS_CLU) >> 2;
            RG_MC: d = (a - OFS_MC) >> 2;
            RG_OE: d = (a - OFS_OE) >> 2;
            default: d = '0;
        endcase
        dec_idx = d[5:0];
    endfunction

    // switch matrix, product terms and allocator
    always_comb begin
        src = {other_fb, st_r.fb, ckp_in, ded_in}; // RULE1 RULE4
        for (int i = 0; i < NUM_SW; i++) begin
            sw[i] = pick_src(src, st_r.sel[i]); // RULE3
        end
        lits = {~sw, sw};
        for (int t = 0; t < NUM_PT; t++) begin
            pt[t] = (|st_r.mask[t]) && (&(~st_r.mask[t] | lits)); // RULE2 RULE5
        end
        sum = '0;
        for (int c = 0; c < NUM_CLU; c++) begin
            int tgt;
            tgt = c - 2 + int'(st_r.steer[c][1:0]); // RULE7
            if (st_r.steer[c][CLU_EN_BIT] && tgt >= 0 && tgt < NUM_MC) begin
                sum[tgt] = sum[tgt] | (|pt[c*CLU_PT +: CLU_PT]); // RULE6
            end
        end
    end

    assign rg = dec_grp(paddr);
    assign ridx = dec_idx(paddr, rg);

    // next state of macrocells, pins and bus slave
    always_comb begin
        st_nxt = st_r;
        ck_rise = ckp_in & ~st_r.ckp_q;
        for (int m = 0; m < NUM_MC; m++) begin
            logic [1:0] cs;
            logic d;
            logic buried;
            plb_mode_type md;
            cs = st_r.mccfg[m][MC_CLK_LSB +: 2]; // RULE11
            md = plb_mode_type'(st_r.mccfg[m][MC_MODE_LSB +: 3]);
            buried = (m % 2) == 1;
            d = sum[m];
            if (buried && (md == MC_INREG || md == MC_INLATCH)) begin
                d = io_in[m / 2]; // RULE16
            end
            qn[m] = st_r.q[m];
            case (md)
                MC_COMB: qn[m] = d; // RULE8
                MC_REG, MC_INREG: begin
                    if (ck_rise[cs]) begin // RULE12
                        if (st_r.mccfg[m][MC_TTYPE_BIT] && md == MC_REG) begin
                            qn[m] = st_r.q[m] ^ d; // RULE10 RULE20
                        end else begin
                            qn[m] = d;
                        end
                    end
                end
                MC_LATCH, MC_INLATCH: begin
                    if (!ckp_in[cs]) begin
                        qn[m] = d; // RULE13
                    end
                end
                default: qn[m] = d;
            endcase
            if (md != MC_COMB) begin
                if (pt[PT_RST]) begin
                    qn[m] = 1'b0; // RULE14 RULE21
                end else if (pt[PT_PRE]) begin
                    qn[m] = 1'b1; // RULE14
                end
            end
            st_nxt.q[m] = qn[m];
            st_nxt.fb[m] = qn[m] ^ st_r.mccfg[m][MC_INV_BIT]; // RULE9 RULE15
        end
        st_nxt.ckp_q = ckp_in;
        // pin cells: even macrocells drive pins, pins always feed back
        for (int k = 0; k < NUM_PIN; k++) begin
            st_nxt.io_out[k] = qn[2*k] ^ st_r.mccfg[2*k][MC_INV_BIT];
            case (plb_oe_type'(st_r.oecfg[k]))
                OE_OFF: st_nxt.io_oe_n[k] = 1'b1; // RULE17
                OE_ON: st_nxt.io_oe_n[k] = 1'b0; // RULE17
                OE_PT0: st_nxt.io_oe_n[k] = ~pt[PT_OE0]; // RULE18
                OE_PT1: st_nxt.io_oe_n[k] = ~pt[PT_OE1]; // RULE18
                default: st_nxt.io_oe_n[k] = 1'b1;
            endcase
            st_nxt.fb[NUM_MC + k] = io_in[k]; // RULE19
        end
        // apb slave: answers in the first access cycle
        st_nxt.pready = psel && !penable;
        st_nxt.pslverr = psel && !penable && (rg == RG_NONE || (rg == RG_STAT && pwrite));
        st_nxt.prdata = RST_DATA;
        if (psel && !penable && !pwrite) begin
            case (rg)
                RG_SEL: st_nxt.prdata = 32'(st_r.sel[ridx]);
                RG_TLO: st_nxt.prdata = st_r.mask[ridx][31:0];
                RG_THI: st_nxt.prdata = 32'(st_r.mask[ridx][NUM_LIT-1:32]);
                RG_CLU: st_nxt.prdata = 32'(st_r.steer[ridx]);
                RG_MC: st_nxt.prdata = 32'(st_r.mccfg[ridx]);
                RG_OE: st_nxt.prdata = 32'(st_r.oecfg[ridx]);
                RG_STAT: st_nxt.prdata = 32'({io_in, st_r.q});
                default: st_nxt.prdata = RST_DATA;
            endcase
        end
        if (psel && penable && st_r.pready && pwrite) begin
            case (rg)
                RG_SEL: st_nxt.sel[ridx] = pwdata[SEL_W-1:0];
                RG_TLO: st_nxt.mask[ridx][31:0] = pwdata;
                RG_THI: st_nxt.mask[ridx][NUM_LIT-1:32] = pwdata[TERM_HI_W-1:0];
                RG_CLU: st_nxt.steer[ridx] = pwdata[2:0];
                RG_MC: st_nxt.mccfg[ridx] = pwdata[MC_CFG_W-1:0];
                RG_OE: st_nxt.oecfg[ridx] = pwdata[1:0];
                default: st_nxt.q = st_nxt.q; // read-only or unmapped
            endcase
        end
    end

    // single state register, frozen while ce is low unless rst is high
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= '0;
            st_r.io_oe_n <= '1;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign io_out = st_r.io_out;
    assign io_oe_n = st_r.io_oe_n;
    assign fb_out = st_r.fb;
    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;

    // checks on macrocell 0, pin 0 and apb ready
    a_reset_wins: assert property (@(posedge clk) disable iff (rst) // RULE21
        (ce && pt[PT_RST] && pt[PT_PRE] && st_r.mccfg[0][2:0] == 3'h1) |=> (st_r.q[0] == 1'b0))
        else $error("reset did not win over preset");
    a_preset_sets: assert property (@(posedge clk) disable iff (rst) // RULE14
        (ce && !pt[PT_RST] && pt[PT_PRE] && st_r.mccfg[0][2:0] != 3'h0) |=> st_r.q[0])
        else $error("preset did not set macrocell");
    a_oe_off: assert property (@(posedge clk) disable iff (rst) // RULE17
        (ce && st_r.oecfg[0] == 2'h0) |=> io_oe_n[0])
        else $error("pin driven while disabled");
    a_oe_term: assert property (@(posedge clk) disable iff (rst) // RULE18
        (ce && st_r.oecfg[0] == 2'h2) |=> (io_oe_n[0] == !$past(pt[PT_OE0])))
        else $error("pin enable not following first term");
    a_reg_holds: assert property (@(posedge clk) disable iff (rst) // RULE12
        (ce && st_r.mccfg[0][2:0] == 3'h1 && !ck_rise[st_r.mccfg[0][6:5]] && !pt[PT_RST] && !pt[PT_PRE])
        |=> $stable(st_r.q[0]))
        else $error("register changed without clock edge");
    a_t_toggle: assert property (@(posedge clk) disable iff (rst) // RULE20
        (ce && st_r.mccfg[0][3:0] == 4'h9 && ck_rise[st_r.mccfg[0][6:5]] && sum[0] && !pt[PT_RST] && !pt[PT_PRE])
        |=> (st_r.q[0] != $past(st_r.q[0])))
        else $error("t register did not toggle");
    a_latch_pass: assert property (@(posedge clk) disable iff (rst) // RULE13
        (ce && st_r.mccfg[0][2:0] == 3'h2 && !ckp_in[st_r.mccfg[0][6:5]] && !pt[PT_RST] && !pt[PT_PRE])
        |=> (st_r.q[0] == $past(sum[0])))
        else $error("open latch did not pass input");
    a_pin_fb: assert property (@(posedge clk) disable iff (rst) // RULE19
        ce |=> (fb_out[NUM_MC] == $past(io_in[0])))
        else $error("pin feedback lost");
    a_apb_ready: assert property (@(posedge clk) disable iff (rst)
        (ce && psel && !penable) |=> (pready ##1 !pready))
        else $error("apb ready not a single access cycle");

    // checks on storage modes of macrocell 0
    a_comb_follows: assert property (@(posedge clk) disable iff (rst) // RULE8
        (ce && st_r.mccfg[0][2:0] == 3'h0)
        |=> (st_r.q[0] == $past(sum[0])))
        else $error("combinational macrocell not following its sum");
    a_d_capture: assert property (@(posedge clk) disable iff (rst) // RULE12
        (ce && st_r.mccfg[0][3:0] == 4'h1 && ck_rise[st_r.mccfg[0][6:5]]
            && !pt[PT_RST] && !pt[PT_PRE])
        |=> (st_r.q[0] == $past(sum[0])))
        else $error("d register did not capture on clock edge");
    a_t_holds: assert property (@(posedge clk) disable iff (rst) // RULE20
        (ce && st_r.mccfg[0][3:0] == 4'h9 && ck_rise[st_r.mccfg[0][6:5]] && !sum[0]
            && !pt[PT_RST] && !pt[PT_PRE])
        |=> $stable(st_r.q[0]))
        else $error("t register toggled with zero input");
    a_latch_hold: assert property (@(posedge clk) disable iff (rst) // RULE13
        (ce && st_r.mccfg[0][2:0] == 3'h2 && ckp_in[st_r.mccfg[0][6:5]]
            && !pt[PT_RST] && !pt[PT_PRE])
        |=> $stable(st_r.q[0]))
        else $error("closed latch changed");
    a_reset_clears: assert property (@(posedge clk) disable iff (rst) // RULE14
        (ce && pt[PT_RST] && st_r.mccfg[0][2:0] != 3'h0)
        |=> !st_r.q[0])
        else $error("shared reset term did not clear macrocell");

    // checks on polarity, feedback and pin enable
    a_pin_polarity: assert property (@(posedge clk) disable iff (rst) // RULE8
        ce
        |=> (io_out[0] == (st_r.q[0] ^ $past(st_r.mccfg[0][MC_INV_BIT]))))
        else $error("pin value lost its polarity");
    a_fb_polarity: assert property (@(posedge clk) disable iff (rst) // RULE9
        ce
        |=> (fb_out[0] == (st_r.q[0] ^ $past(st_r.mccfg[0][MC_INV_BIT]))))
        else $error("output macrocell feedback wrong");
    a_buried_fb: assert property (@(posedge clk) disable iff (rst) // RULE15
        ce
        |=> (fb_out[1] == (st_r.q[1] ^ $past(st_r.mccfg[1][MC_INV_BIT]))))
        else $error("buried macrocell feedback wrong");
    a_oe_on: assert property (@(posedge clk) disable iff (rst) // RULE17
        (ce && st_r.oecfg[0] == 2'h1)
        |=> !io_oe_n[0])
        else $error("pin not driven while always enabled");

    // checks on matrix, terms and allocator
    a_sel_ded: assert property (@(posedge clk) disable iff (rst) // RULE1 RULE3
        (ce && st_r.sel[0] == 8'h00)
        |-> (sw[0] == ded_in[0]))
        else $error("matrix input 0 not taken from dedicated input");
    a_term_empty: assert property (@(posedge clk) disable iff (rst) // RULE5
        (ce && st_r.mask[PT_RST] == '0)
        |-> !pt[PT_RST])
        else $error("empty reset term asserted");
    a_cluster_route: assert property (@(posedge clk) disable iff (rst) // RULE6 RULE7
        (ce && st_r.steer[0] == 3'h6 && (|pt[3:0]))
        |-> sum[0])
        else $error("cluster 0 not reaching macrocell 0");

    // checks on bus slave, reset and clock enable
    a_rst_idle: assert property (@(posedge clk) // RULE17
        rst
        |=> (io_oe_n == 6'h3f && !pready && fb_out == '0))
        else $error("outputs not idle after reset");
    a_ce_freeze: assert property (@(posedge clk) disable iff (rst)
        !ce
        |=> ($stable(io_out) && $stable(io_oe_n) && $stable(fb_out) && $stable(pready)))
        else $error("state moved while clock enable low");
    a_access_low: assert property (@(posedge clk) disable iff (rst)
        (ce && psel && penable)
        |=> !pready)
        else $error("ready raised outside first access cycle");
    a_unaligned_err: assert property (@(posedge clk) disable iff (rst)
        (ce && psel && !penable && paddr[1:0] != 2'h0)
        |=> (pready && pslverr))
        else $error("unaligned access not refused");
    a_stat_refuse: assert property (@(posedge clk) disable iff (rst)
        (ce && psel && !penable && pwrite && paddr == OFS_STAT)
        |=> (pready && pslverr))
        else $error("status write not refused");
    a_sel_write: assert property (@(posedge clk) disable iff (rst) // RULE3
        (ce && psel && penable && pready && pwrite && paddr == OFS_SEL)
        |=> (st_r.sel[0] == $past(pwdata[SEL_W-1:0])))
        else $error("selector write lost");
    a_write_waits: assert property (@(posedge clk) disable iff (rst)
        (ce && psel && penable && !pready && pwrite && paddr == OFS_MC)
        |=> $stable(st_r.mccfg[0]))
        else $error("write landed without ready");
endmodule
`default_nettype wire

// File: hdl/plb_pkg.sv
// constants, field layouts and register map of one programmable logic block
// assumes an apb master with 32-bit data and a 40 MHz system clock
//
// Function
// [RULE1] matrix takes pins, dedicated inputs and clock pins
// [RULE2] block holds array, allocator, twelve macrocells, six pins
// [RULE3] twenty-six selectable matrix inputs per block
// [RULE4] twelve macrocell and six pin feedbacks returned
// [RULE5] four special terms: two enables, reset, preset
// [RULE6] allocator shares 48 terms, sixteen per macrocell
// [RULE7] macrocell n reaches clusters n-1 to n+2
// [RULE8] output macrocell registered, latched or combinational, polarity
// [RULE9] every macrocell always feeds back internally
// [RULE10] register selectable as d-type or t-type
// [RULE11] each storage element picks one of four clock pins
// [RULE12] registers capture on rising selected clock
// [RULE13] latch transparent on low gate, holds high
// [RULE14] shared reset and preset terms act on all
// [RULE15] buried macrocell same logic, feedback only
// [RULE16] buried macrocell may be input register or latch
// [RULE17] pin driver always on, always off, or term
// [RULE18] term control picks one of two shared enables
// [RULE19] disabled pin still feeds back as input
// [RULE20] t-type toggles on clock when input is one
// [RULE21] reset wins over simultaneous preset
package plb_pkg;
    localparam int NUM_MC = 12;
    localparam int NUM_PIN = 6;
    localparam int NUM_SW = 26;
    localparam int NUM_LIT = 2 * NUM_SW;
    localparam int NUM_LPT = 48;
    localparam int NUM_PT = NUM_LPT + 4;
    localparam int PT_OE0 = 48;
    localparam int PT_OE1 = 49;
    localparam int PT_RST = 50;
    localparam int PT_PRE = 51;
    localparam int CLU_PT = 4;
    localparam int NUM_CLU = NUM_LPT / CLU_PT;
    localparam int NUM_DED = 4;
    localparam int NUM_CKP = 4;
    localparam int NUM_BLK = 8;
    localparam int FB_PER_BLK = NUM_MC + NUM_PIN;
    localparam int EXT_FB = (NUM_BLK - 1) * FB_PER_BLK;
    localparam int SRC_FB = NUM_DED + NUM_CKP;
    localparam int NUM_SRC = SRC_FB + FB_PER_BLK + EXT_FB;
    localparam int SEL_W = 8;
    localparam int AW = 12;
    // register map (byte addresses)
    localparam logic [AW-1:0] OFS_SEL = 12'h000;
    localparam logic [AW-1:0] OFS_TERM = 12'h100;
    localparam logic [AW-1:0] OFS_CLU = 12'h300;
    localparam logic [AW-1:0] OFS_MC = 12'h380;
    localparam logic [AW-1:0] OFS_OE = 12'h3c0;
    localparam logic [AW-1:0] OFS_STAT = 12'h3e0;
    // field positions
    localparam int CLU_EN_BIT = 2;
    localparam int MC_MODE_LSB = 0;
    localparam int MC_TTYPE_BIT = 3;
    localparam int MC_INV_BIT = 4;
    localparam int MC_CLK_LSB = 5;
    localparam int MC_CFG_W = 7;
    localparam int TERM_HI_W = NUM_LIT - 32;
    localparam logic [31:0] RST_DATA = 32'h0000_0000;
    typedef enum logic [2:0] {MC_COMB, MC_REG, MC_LATCH, MC_INREG, MC_INLATCH} plb_mode_type;
    typedef enum logic [1:0] {OE_OFF, OE_ON, OE_PT0, OE_PT1} plb_oe_type;
    typedef enum logic [2:0] {RG_SEL, RG_TLO, RG_THI, RG_CLU, RG_MC, RG_OE, RG_STAT, RG_NONE} plb_reg_type;
endpackage
